// ===== tb/cfp_assertions.sv
// Concurrent checks on the wires between the host and device ends.
`timescale 1ns/1ps
module cfp_assertions
    import cfp_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_nrst,
    input  wire logic       clk_dev_oe,
    input  wire logic       clk_host_oe,
    input  wire logic [7:0] data,
    input  wire logic       cs_n,
    input  wire logic       cfg_write_n,
    input  wire logic       busy_dout,
    input  wire logic       busy_dout_oe,
    input  wire logic       init_dev_oe,
    input  wire logic       init_host_oe,
    input  wire logic       done_dev_oe,
    input  wire logic       cfg_reset_n,
    input  wire logic [2:0] cfg_mode_sel,
    input  wire logic       sleep_req_n,
    input  wire logic       cfg_clk,
    input  wire logic       init_n,
    input  wire logic       done
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);

    logic ser;
    logic mst;
    assign ser = (cfg_mode_sel == MODE_MSER) || (cfg_mode_sel == MODE_SSER);
    assign mst = (cfg_mode_sel == MODE_MSER) || (cfg_mode_sel == MODE_MPAR);

    sleep_high_a: assert property ($past(i_nrst) |-> sleep_req_n)
        else $error("sleep request driven low");
    write_dir_a: assert property (!cs_n |-> !cfg_write_n)
        else $error("selected without write direction");
    clk_single_a: assert property (!(clk_dev_oe && clk_host_oe))
        else $error("both ends drive the clock");
    dev_clk_a: assert property ($rose(clk_dev_oe) |-> mst)
        else $error("device drives clock in slave mode");
    host_clk_a: assert property ($rose(clk_host_oe) |-> !mst)
        else $error("host drives clock in master mode");
    prog_reset_a: assert property (!cfg_reset_n |-> !init_dev_oe &&
        !done_dev_oe && !clk_dev_oe && !busy_dout_oe)
        else $error("device active during program pulse");
    clear_init_a: assert property ($rose(cfg_reset_n) |->
        ##[1:4] (init_dev_oe && done_dev_oe))
        else $error("init not held low while clearing");
    init_hold_a: assert property (init_host_oe && !clk_dev_oe |=>
        !clk_dev_oe)
        else $error("loading started while init held low");
    serial_fwd_a: assert property ($rose(cfg_clk) && busy_dout_oe
        && ser |-> ##4 (!busy_dout_oe || busy_dout == $past(data[0], 4)))
        else $error("serial output does not follow data");

    cover property ($rose(done));
    cover property ($fell(init_n) && !init_host_oe && cfg_reset_n);
    cover property ($rose(busy_dout_oe) ##1 (busy_dout_oe && !ser));
endmodule : cfp_assertions

// ===== tb/fpga_config_port_pins_bench.sv
// Self-checking bench joining the host and device ends of the port.
`timescale 1ns/1ps
module fpga_config_port_pins_bench
    import cfp_pkg::*;
();
    localparam int NB = 4;
    logic       i_ref_clk, i_nrst, h_start, h_pu, h_hold_i, h_hold_s;
    logic       h_valid, h_ready, h_done, h_err;
    logic [2:0] h_mode;
    logic [7:0] h_data, d_data, e;
    logic       d_ready, d_derr, d_keep, d_dwait, d_valid, d_error;
    logic       d_done, d_pu, d_uio;
    int         failures, check_count, cycles, pops, stall;
    logic [7:0] exp_q[$];

    cfp_if link ();
    cfp_host #(.HALF(CLK_HALF), .N_PROG(PROG_CYCLES)) u_cfp_host (
        .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .link(link),
        .i_start(h_start), .i_mode(h_mode), .i_pullup_en(h_pu),
        .i_hold_init(h_hold_i), .i_hold_start(h_hold_s),
        .i_data(h_data), .i_valid(h_valid), .o_ready(h_ready),
        .o_done(h_done), .o_error(h_err));
    cfp_dev #(.N_BYTES(NB), .N_CLR(4), .HALF(CLK_HALF)) u_cfp_dev (
        .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .link(link),
        .i_ready(d_ready), .i_data_err(d_derr), .i_keep_port(d_keep),
        .i_done_wait(d_dwait), .o_data(d_data), .o_valid(d_valid),
        .o_error(d_error), .o_done(d_done), .o_io_pullup(d_pu),
        .o_user_io_en(d_uio));
    cfp_assertions u_cfp_assertions (
        .i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .clk_dev_oe(link.clk_dev_oe), .clk_host_oe(link.clk_host_oe),
        .data(link.data), .cs_n(link.cs_n), .cfg_write_n(link.cfg_write_n),
        .busy_dout(link.busy_dout), .busy_dout_oe(link.busy_dout_oe),
        .init_dev_oe(link.init_dev_oe), .init_host_oe(link.init_host_oe),
        .done_dev_oe(link.done_dev_oe), .cfg_reset_n(link.cfg_reset_n),
        .cfg_mode_sel(link.cfg_mode_sel), .sleep_req_n(link.sleep_req_n),
        .cfg_clk(link.cfg_clk), .init_n(link.init_n), .done(link.done));

    initial begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end

    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        check_count++;
        if (got !== ex) begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", nm, ex, got);
        end
    endtask : chk

    task automatic summarize();
        if (failures == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask : tick

    // Feeds the host one byte at a time; an error pulse follows byte one.
    task automatic send(input bit keep_two, input bit err);
        logic [7:0] b;
        for (int i = 0; i < NB; i++) begin
            b = 8'($urandom_range(0, 255));
            h_data <= b;
            h_valid <= 1'b1;
            @(posedge i_ref_clk);
            while (h_ready !== 1'b1) @(posedge i_ref_clk);
            if (!keep_two || i < 2) exp_q.push_back(b);
            if (err && i == 0) begin
                h_valid <= 1'b0;
                tick(20);
                d_derr <= 1'b1;
                tick(1);
                d_derr <= 1'b0;
                tick(8);
                chk("init_n", 0, link.init_n);
                chk("host_error", 1, h_err);
            end
        end
        h_valid <= 1'b0;
    endtask : send

    // Flags: 0 hold init, 1 done wait, 2 data error and keep, 3 stall.
    task automatic run(input logic [2:0] m, input logic [3:0] f);
        logic par;
        logic pu;
        int   n;
        par = (m == MODE_MPAR) || (m == MODE_SPAR);
        pu = 1'($urandom_range(0, 1));
        pops = 0;
        h_mode <= m;
        h_pu <= pu;
        h_hold_i <= f[0];
        h_hold_s <= f[1];
        d_dwait <= f[1];
        d_keep <= f[2];
        h_start <= 1'b1;
        tick(1);
        h_start <= 1'b0;
        if (m != MODE_MSER) begin
            tick(100);
            chk("held_pops", 0, pops);
            if (f[0]) chk("clk_dev_oe", 0, link.clk_dev_oe);
        end
        h_hold_i <= 1'b0;
        if (f[3]) stall = par ? 300 : 5000;
        fork
            send(f[3] && !par, f[2]);
            begin
                tick(40);
                chk("o_io_pullup", pu, d_pu);
                if (f[3] && par) begin
                    tick(210);
                    chk("busy_dout", 1, link.busy_dout);
                end
            end
        join
        if (f[1]) begin
            tick(300);
            chk("early_done", 0, d_done);
            h_hold_s <= 1'b0;
        end
        n = 0;
        while (d_done !== 1'b1 && n < 3000) begin
            tick(1);
            n++;
        end
        stall = 0;
        tick(6);
        chk("o_done", 1, d_done);
        chk("done_pins", 3, {h_done, link.done});
        chk("o_error", f[2] || (f[3] && !par), d_error);
        chk("o_user_io_en", !(par && f[2]), d_uio);
        chk("pullup_off", 0, d_pu);
        n = 0;
        while (exp_q.size() > 0 && n < 500) begin
            tick(1);
            n++;
        end
        chk("left_bytes", 0, exp_q.size());
    endtask : run

    always @(posedge i_ref_clk) begin
        if (i_nrst && d_valid === 1'b1 && d_ready === 1'b1) begin
            pops++;
            e = (exp_q.size() > 0) ? exp_q.pop_front() : ~d_data;
            chk("o_data", e, d_data);
        end
        d_ready <= (stall == 0) && ($urandom_range(0, 1) == 1);
        if (stall > 0) stall--;
    end

    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            summarize();
        end
    end

    initial begin
        void'($urandom(32'hE533AB80));
        i_nrst = 1'b0;
        h_start = 1'b0;
        h_mode = MODE_SSER;
        h_pu = 1'b0;
        h_hold_i = 1'b0;
        h_hold_s = 1'b0;
        h_data = 8'h00;
        h_valid = 1'b0;
        d_ready = 1'b0;
        d_derr = 1'b0;
        d_keep = 1'b0;
        d_dwait = 1'b0;
        failures = 0;
        check_count = 0;
        cycles = 0;
        pops = 0;
        stall = 0;
        tick(12);
        i_nrst <= 1'b1;
        tick(4);
        run(MODE_MSER, 4'h0);
        run(MODE_MPAR, 4'h9);
        run(MODE_SPAR, 4'h4);
        run(MODE_SSER, 4'h2);
        run(MODE_SSER, 4'h8);
        summarize();
    end
endmodule : fpga_config_port_pins_bench

// ===== verilog/cfp_dev.sv
// Device end of the configuration port: loader, buffer and handshakes.
// Behaviour
// - Parallel mode loads bytes, then releases pins unless i_keep_port is set.
// - Serial modes shift bits on lowest pin.
// - Host selects device with chip select low.
// - Host drives write direction low to write.
// - Busy paces parallel bytes; host obeys it.
// - Serial modes forward bits to next device.
// - Init held low while memory clears.
// - External low init postpones configuration start.
// - Data error pulls init low during configuration.
// - Clock driven in master, host supplies slave.
// - Program pin low resets logic asynchronously.
// - Completion pin shows configuration has finished.
// - Optional external low completion delays start-up.
// - Pull-up enable turns on I/O pull-ups until start-up.
// - Host never drives power-down input low.
`timescale 1ns/1ps
module cfp_dev
    import cfp_pkg::*;
#(
    parameter int N_BYTES = CFG_BYTES,
    parameter int N_CLR   = CLR_CYCLES,
    parameter int HALF    = CLK_HALF
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_nrst,
    cfp_if.dev              link,
    input  wire logic       i_ready,
    input  wire logic       i_data_err,
    input  wire logic       i_keep_port,
    input  wire logic       i_done_wait,
    output logic [7:0]      o_data,
    output logic            o_valid,
    output logic            o_error,
    output logic            o_done,
    output logic            o_io_pullup,
    output logic            o_user_io_en
);
    typedef enum logic [2:0] {
        ST_CLEAR = 3'b000,
        ST_WINIT = 3'b001,
        ST_LOAD  = 3'b010,
        ST_WDONE = 3'b011,
        ST_RUN   = 3'b100
    } cfp_dst_e;

    typedef struct packed {
        cfp_dst_e     st;
        logic [2:0]   mode;
        logic [P_W-1:0] s1;
        logic [P_W-1:0] s2;
        logic         ckp;
        logic [15:0]  cnt;
        logic [15:0]  nbytes;
        logic [7:0]   sh;
        logic [2:0]   bitc;
        logic [7:0]   mem0;
        logic [7:0]   mem1;
        logic         v0;
        logic         v1;
        logic         err;
        logic         clk;
        logic         clk_oe;
        logic [7:0]   div;
        logic         bd;
        logic         bd_oe;
        logic         init_oe;
        logic         done_oe;
        logic         done;
        logic         pull;
        logic         io_en;
    } cfp_dst_s;

    localparam cfp_dst_s RST = '{st: ST_CLEAR, default: '0};

    cfp_dst_s q;
    cfp_dst_s d;

    always_comb begin
        logic       master;
        logic       par;
        logic       rise;
        logic       push;
        logic [7:0] byte_in;
        master  = cfp_is_master(q.mode);
        par     = cfp_is_par(q.mode);
        rise    = q.s2[P_CK] & ~q.ckp;
        push    = 1'b0;
        byte_in = q.s2[P_D +: 8];
        d       = q;
        d.s1    = {link.cfg_mode_sel, link.data, link.cfg_pullup_en,
                   link.done, link.init_n, link.cfg_write_n, link.cs_n,
                   link.cfg_clk};
        d.s2    = q.s1;
        d.ckp   = q.s2[P_CK];
        if (i_ready && q.v0) begin
            d.mem0 = q.mem1;
            d.v0   = q.v1;
            d.v1   = 1'b0;
        end
        unique case (q.st)
            ST_CLEAR: begin
                d.init_oe = 1'b1;
                d.done_oe = 1'b1;
                d.mode    = q.s2[P_M +: 3];
                d.cnt     = q.cnt + 16'h0001;
                if (q.cnt == 16'(N_CLR - 1)) begin
                    d.st      = ST_WINIT;
                    d.init_oe = 1'b0;
                    d.cnt     = 16'h0000;
                end
            end
            ST_WINIT: begin
                if (q.s2[P_INIT]) begin
                    d.st = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (master) begin
                    d.clk_oe = 1'b1;
                    d.div    = q.div + 8'h01;
                    if (q.div == 8'(HALF - 1)) begin
                        d.div = 8'h00;
                        d.clk = ~q.clk;
                    end
                end
                if (rise && !par) begin
                    d.sh   = {q.sh[6:0], q.s2[P_D]};
                    d.bd   = q.s2[P_D];
                    d.bitc = q.bitc + 3'h1;
                    push   = (q.bitc == 3'h7);
                    byte_in = {q.sh[6:0], q.s2[P_D]};
                end
                if (rise && par && !q.s2[P_CS] && !q.s2[P_WR]
                    && !q.bd) begin
                    push = 1'b1;
                end
                if (push) begin
                    d.nbytes = q.nbytes + 16'h0001;
                    if (!d.v0) begin
                        d.mem0 = byte_in;
                        d.v0   = 1'b1;
                    end else if (!d.v1) begin
                        d.mem1 = byte_in;
                        d.v1   = 1'b1;
                    end else begin
                        d.err = 1'b1;
                    end
                    if (q.nbytes == 16'(N_BYTES - 1)) begin
                        d.st     = ST_WDONE;
                        d.clk_oe = 1'b0;
                    end
                end
                if (i_data_err) begin
                    d.err = 1'b1;
                end
                d.init_oe = d.err;
                if (par) begin
                    d.bd = d.v0 | d.v1;
                end
            end
            ST_WDONE: begin
                d.done_oe = 1'b0;
                if (!i_done_wait || q.s2[P_DONE]) begin
                    d.st      = ST_RUN;
                    d.done    = 1'b1;
                    d.init_oe = 1'b0;
                end
            end
            ST_RUN: begin
                d.io_en = !(par && i_keep_port);
            end
            default: begin
                d.st = ST_CLEAR;
            end
        endcase
        d.bd_oe = (d.st == ST_LOAD) || (d.st == ST_WDONE)
                  || (par && i_keep_port);
        d.pull  = q.s2[P_PU] && (q.st != ST_RUN);
        if (!i_nrst) begin
            d = RST;
        end
    end

    always_ff @(posedge i_ref_clk or negedge link.cfg_reset_n) begin
        if (!link.cfg_reset_n) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

    assign link.clk_dev_o    = q.clk;
    assign link.clk_dev_oe   = q.clk_oe;
    assign link.busy_dout_o  = q.bd;
    assign link.busy_dout_oe = q.bd_oe;
    assign link.init_dev_oe  = q.init_oe;
    assign link.done_dev_oe  = q.done_oe;
    assign o_data            = q.mem0;
    assign o_valid           = q.v0;
    assign o_error           = q.err;
    assign o_done            = q.done;
    assign o_io_pullup       = q.pull;
    assign o_user_io_en      = q.io_en;
endmodule : cfp_dev

// ===== verilog/cfp_host.sv
// Host end of the configuration port: program pulse, clock and data.
`timescale 1ns/1ps
module cfp_host
    import cfp_pkg::*;
#(
    parameter int HALF   = CLK_HALF,
    parameter int N_PROG = PROG_CYCLES
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_nrst,
    cfp_if.host             link,
    input  wire logic       i_start,
    input  wire logic [2:0] i_mode,
    input  wire logic       i_pullup_en,
    input  wire logic       i_hold_init,
    input  wire logic       i_hold_start,
    input  wire logic [7:0] i_data,
    input  wire logic       i_valid,
    output logic            o_ready,
    output logic            o_done,
    output logic            o_error
);
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_PROG = 2'b01,
        HS_WAIT = 2'b10,
        HS_SEND = 2'b11
    } cfp_hst_e;

    typedef struct packed {
        cfp_hst_e    st;
        logic [2:0]  mode;
        logic [3:0]  s1;
        logic [3:0]  s2;
        logic        ckp;
        logic [7:0]  cnt;
        logic        clk;
        logic        clk_oe;
        logic [7:0]  div;
        logic [7:0]  dat;
        logic        doe;
        logic        cs_n;
        logic        wr_n;
        logic [7:0]  sh;
        logic [2:0]  bitc;
        logic [7:0]  byte_q;
        logic        full;
        logic        rdy;
        logic        prog_n;
        logic        hinit;
        logic        hdone;
        logic        pu;
        logic        done;
        logic        err;
    } cfp_hst_s;

    localparam cfp_hst_s RST = '{st: HS_IDLE, prog_n: 1'b1, cs_n: 1'b1,
                                 wr_n: 1'b1, clk: 1'b1, default: '0};

    cfp_hst_s q;
    cfp_hst_s d;

    always_comb begin
        logic master;
        logic par;
        logic fall;
        master = cfp_is_master(q.mode);
        par    = cfp_is_par(q.mode);
        fall   = 1'b0;
        d      = q;
        d.s1   = {link.done, link.init_n, link.busy_dout, link.cfg_clk};
        d.s2   = q.s1;
        d.ckp  = q.s2[H_CK];
        d.hinit = i_hold_init;
        d.hdone = i_hold_start;
        d.pu    = i_pullup_en;
        if (i_valid && q.rdy) begin
            d.byte_q = i_data;
            d.full   = 1'b1;
        end
        unique case (q.st)
            HS_IDLE: begin
                d.mode = i_mode;
                if (i_start) begin
                    d.st     = HS_PROG;
                    d.prog_n = 1'b0;
                    d.cnt    = 8'h00;
                end
            end
            HS_PROG: begin
                d.cnt = q.cnt + 8'h01;
                if (q.cnt == 8'(N_PROG - 1)) begin
                    d.st     = HS_WAIT;
                    d.prog_n = 1'b1;
                    d.cnt    = 8'h00;
                end
            end
            HS_WAIT: begin
                if (q.cnt != 8'(N_PROG - 1)) begin
                    d.cnt = q.cnt + 8'h01;
                end else if (q.s2[H_INIT] && !i_hold_init) begin
                    d.st = HS_SEND;
                end
            end
            HS_SEND: begin
                if (master) begin
                    fall = q.ckp & ~q.s2[H_CK];
                end else begin
                    d.clk_oe = 1'b1;
                    if (par || !q.clk || q.full || q.bitc != 3'h0) begin
                        d.div = q.div + 8'h01;
                        if (q.div == 8'(HALF - 1)) begin
                            d.div = 8'h00;
                            d.clk = ~q.clk;
                            fall  = q.clk;
                        end
                    end
                end
                if (fall && par) begin
                    d.cs_n = 1'b1;
                    d.wr_n = 1'b1;
                    // A skipped period after each byte lets busy reach us.
                    if (q.full && q.cs_n && !q.s2[H_BUSY]) begin
                        d.dat  = q.byte_q;
                        d.doe  = 1'b1;
                        d.cs_n = 1'b0;
                        d.wr_n = 1'b0;
                        d.full = 1'b0;
                    end
                end else if (fall) begin
                    d.doe = 1'b1;
                    if (q.bitc != 3'h0) begin
                        d.dat  = {7'h00, q.sh[7]};
                        d.sh   = {q.sh[6:0], 1'b0};
                        d.bitc = q.bitc - 3'h1;
                    end else if (q.full) begin
                        d.dat  = {7'h00, q.byte_q[7]};
                        d.sh   = {q.byte_q[6:0], 1'b0};
                        d.bitc = 3'h7;
                        d.full = 1'b0;
                    end
                end
                d.done = q.s2[H_DONE];
                d.err  = !q.s2[H_INIT];
                if (i_start) begin
                    d = RST;
                    d.st     = HS_PROG;
                    d.prog_n = 1'b0;
                    d.mode   = i_mode;
                end
            end
        endcase
        d.rdy = !d.full;
        if (!i_nrst) begin
            d = RST;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        q <= d;
    end

    assign link.clk_host_o    = q.clk;
    assign link.clk_host_oe   = q.clk_oe;
    assign link.data_o        = q.dat;
    assign link.data_oe       = q.doe;
    assign link.cs_n          = q.cs_n;
    assign link.cfg_write_n   = q.wr_n;
    assign link.init_host_oe  = q.hinit;
    assign link.done_host_oe  = q.hdone;
    assign link.cfg_reset_n   = q.prog_n;
    assign link.cfg_mode_sel  = q.mode;
    assign link.cfg_pullup_en = q.pu;
    assign link.sleep_req_n   = 1'b1;
    assign o_ready            = q.rdy;
    assign o_done             = q.done;
    assign o_error            = q.err;
endmodule : cfp_host

// ===== verilog/cfp_if.sv
// Configuration port wires between the host and the device.
`timescale 1ns/1ps
interface cfp_if;
    logic       clk_dev_o;
    logic       clk_dev_oe;
    logic       clk_host_o;
    logic       clk_host_oe;
    logic [7:0] data_o;
    logic       data_oe;
    logic       cs_n;
    logic       cfg_write_n;
    logic       busy_dout_o;
    logic       busy_dout_oe;
    logic       init_dev_oe;
    logic       init_host_oe;
    logic       done_dev_oe;
    logic       done_host_oe;
    logic       cfg_reset_n;
    logic [2:0] cfg_mode_sel;
    logic       cfg_pullup_en;
    logic       sleep_req_n;
    logic       cfg_clk;
    logic [7:0] data;
    logic       busy_dout;
    logic       init_n;
    logic       done;

    // Resolved pin levels; undriven pins rest high as if pulled up.
    assign cfg_clk   = clk_dev_oe ? clk_dev_o :
                       (clk_host_oe ? clk_host_o : 1'b1);
    assign data      = data_oe ? data_o : 8'hFF;
    assign busy_dout = busy_dout_oe ? busy_dout_o : 1'b1;
    assign init_n    = ~(init_dev_oe | init_host_oe);
    assign done      = ~(done_dev_oe | done_host_oe);

    modport dev (
        output clk_dev_o, clk_dev_oe, busy_dout_o, busy_dout_oe,
        output init_dev_oe, done_dev_oe,
        input  cfg_clk, data, cs_n, cfg_write_n, init_n, done,
        input  cfg_reset_n, cfg_mode_sel, cfg_pullup_en, sleep_req_n
    );
    modport host (
        output clk_host_o, clk_host_oe, data_o, data_oe, cs_n,
        output cfg_write_n, init_host_oe, done_host_oe, cfg_reset_n,
        output cfg_mode_sel, cfg_pullup_en, sleep_req_n,
        input  cfg_clk, busy_dout, init_n, done
    );
endinterface : cfp_if

// ===== verilog/cfp_pkg.sv
// Shared constants, mode codes and decoders of the configuration port.
package cfp_pkg;
    typedef enum logic [2:0] {
        MODE_MSER = 3'b000,
        MODE_MPAR = 3'b011,
        MODE_SPAR = 3'b110,
        MODE_SSER = 3'b111
    } cfp_mode_e;

    localparam int REF_PERIOD_NS = 25;
    localparam int CLK_PERIOD_NS = 200;
    localparam int CLK_HALF      = CLK_PERIOD_NS / (2 * REF_PERIOD_NS);
    localparam int CLR_CYCLES    = 16;
    localparam int PROG_CYCLES   = 4;
    localparam int CFG_BYTES     = 16;

    // Bit positions in the device's synchronised pin vector.
    localparam int P_CK   = 0;
    localparam int P_CS   = 1;
    localparam int P_WR   = 2;
    localparam int P_INIT = 3;
    localparam int P_DONE = 4;
    localparam int P_PU   = 5;
    localparam int P_D    = 6;
    localparam int P_M    = 14;
    localparam int P_W    = 17;

    // Bit positions in the host's synchronised pin vector.
    localparam int H_CK   = 0;
    localparam int H_BUSY = 1;
    localparam int H_INIT = 2;
    localparam int H_DONE = 3;

    function automatic logic cfp_is_master(input logic [2:0] m);
        cfp_is_master = (m == MODE_MSER) || (m == MODE_MPAR);
    endfunction : cfp_is_master

    function automatic logic cfp_is_par(input logic [2:0] m);
        cfp_is_par = (m == MODE_MPAR) || (m == MODE_SPAR);
    endfunction : cfp_is_par
endpackage : cfp_pkg
